// *** plc_pkg.sv ***
// plc_pkg: register map, field layout and timing of the pll clock controller
package plc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int PLC_CLK_NS = 40; // clk_i period at 25 MHz
    localparam int PLC_RST_HOLD_NS = 125; // least loop reset hold
    localparam int PLC_RST_HOLD_CYC =
        (PLC_RST_HOLD_NS + PLC_CLK_NS - 1) / PLC_CLK_NS;
    localparam int PLC_LOCK_NS = 187500; // least lock wait, 187.5 us
    localparam int PLC_LOCK_CYC =
        (PLC_LOCK_NS + PLC_CLK_NS - 1) / PLC_CLK_NS;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [31:0] PLC_A_PID = 32'h4100_0000;
    localparam logic [31:0] PLC_A_CSR = 32'h4100_0100;
    localparam logic [31:0] PLC_A_MULT = 32'h4100_0110;
    localparam logic [31:0] PLC_A_DIV0 = 32'h4100_0114;
    localparam logic [31:0] PLC_A_DIV1 = 32'h4100_0118;
    localparam logic [31:0] PLC_A_DIV2 = 32'h4100_011C;
    localparam logic [31:0] PLC_A_DIV3 = 32'h4100_0120;
    localparam logic [31:0] PLC_A_CMD = 32'h4100_0138;
    localparam logic [31:0] PLC_A_STAT = 32'h4100_013C;
    localparam logic [31:0] PLC_A_ALN = 32'h4100_0140;
    localparam logic [31:0] PLC_A_CLOCK_ENABLE_CONTROL = 32'h4100_0148;
    localparam logic [31:0] PLC_A_CKST = 32'h4100_014C;
    localparam logic [31:0] PLC_A_SYST = 32'h4100_0150;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PLC_CSR_EN = 0; // loop_select_enable
    localparam int PLC_CSR_RST = 3; // loop_reset_bit
    localparam int PLC_CSR_LOCK = 6; // lock wait elapsed, read only
    localparam int PLC_CSR_SHORT = 7; // reset held too short, w1c
    localparam int PLC_DIV_EN = 15; // divider enable
    localparam int PLC_RAT_W = 5; // ratio field, divide by value+1
    localparam int PLC_CMD_GO = 0; // go_apply_command
    localparam int PLC_STAT_BUSY = 0;
    localparam int PLC_STAT_ERR = 1; // last go refused, bad ratios

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [4:0] PLC_MULT_RST = 5'h0C; // factor 13
    localparam logic [4:0] PLC_MULT_MIN = 5'h03; // factor 4
    localparam logic [4:0] PLC_MULT_MAX = 5'h18; // factor 25
    localparam logic [4:0] PLC_D0_RST = 5'h00; // /1
    localparam logic [4:0] PLC_D1_RST = 5'h00; // /1
    localparam logic [4:0] PLC_D2_RST = 5'h01; // /2
    localparam logic [4:0] PLC_D3_RST = 5'h02; // /3
    localparam logic [31:0] PLC_PID_VAL = 32'h0000_0001; // arbitrary id

    // go sequencing
    typedef enum logic {PLC_GO_IDLE, PLC_GO_APPLY} plc_go_t;

endpackage : plc_pkg

// *** plc_div.sv ***
// plc_div: one programmable clock divider emitting a pulse per period
module plc_div
    import plc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i, // source clock edge
    input wire logic restart_i, // aligned restart
    input wire logic run_i, // divider enabled
    input wire logic [PLC_RAT_W-1:0] ratio_i, // divide by ratio+1
    output logic pulse_o, // one cycle per divided period
    output logic [PLC_RAT_W-1:0] cnt_o // phase of the divider
);

    // ****************************************
    // phase counter
    // ****************************************
    logic [PLC_RAT_W-1:0] cnt_r; // current phase
    logic pulse_r; // registered output pulse

    // count source edges; >= copes with a ratio lowered mid-period
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            cnt_r <= '0;
        end else if (tick_i) begin
            cnt_r <= (cnt_r >= ratio_i) ? '0 : cnt_r + 5'h01;
        end
    end

    // pulse on the last edge of each period
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= run_i && tick_i && (cnt_r >= ratio_i);
        end
    end

    assign pulse_o = pulse_r;
    assign cnt_o = cnt_r;

endmodule : plc_div

// *** plc_ctrl.sv ***
// plc_ctrl: pll clock controller with a classic wishbone register slave
//
// Decided for this implementation: the Wishbone register port.
module plc_ctrl
    import plc_pkg::*;
#(
    parameter int LOCK_CYC = PLC_LOCK_CYC // lock wait in clk_i cycles
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic oscillator_input_i, // on-chip oscillator clock
    input wire logic external_clock_input_i, // clock pin
    output logic core_clk_en_o, // core_system_clock edge
    output logic periph_clk_en_o, // peripheral_system_clock edge
    output logic mem_clk_en_o, // memory_system_clock edge
    output logic ref_clk_en_o, // loop_reference_clock after pre-divider
    output logic loop_select_enable_o // core runs from loop output unless loop reset is held
);

    // ****************************************
    // declarations
    // ****************************************
    logic ack_r; // bus answer
    logic [31:0] rd_r; // read data
    logic [31:0] rdata; // read mux
    logic wr; // write commits at this edge
    logic loop_sel_r; // loop_select_enable
    logic loop_rst_r; // loop_reset_bit
    logic short_r; // reset released too early, sticky
    logic [3:0] rst_cnt_r; // cycles loop reset has been held
    logic [15:0] lock_cnt_r; // lock wait counter
    logic lock_r; // lock wait elapsed
    logic [4:0] mult_r; // multiplier_field, factor-1
    logic [31:0] mult_wr; // multiplier write merged by byte lane
    logic [4:0] d0_r, d1_r, d2_r, d3_r; // written ratios
    logic [3:0] den_r; // written divider enables
    logic [4:0] act_d1, act_d2, act_d3; // applied ratios
    logic [2:0] act_en; // applied enables
    logic [2:0] aln_r; // clock_align_field
    logic clock_enable_control_r; // reference clock output enable
    plc_go_t go_st_r; // go sequencer
    logic go_err_r; // last go refused
    logic restart_r; // aligned restart pulse
    logic go_ok; // pending ratios are legal
    logic act_ok; // applied ratios are legal
    logic osc_s1, osc_s2, ext_s1, ext_s2; // pin synchronisers
    logic ref_lvl_r; // combined reference, delayed
    logic ref_tick; // reference rising edge
    logic loop_run; // loop feeds the post-dividers
    logic sys_tick; // source edge for the post-dividers
    logic aux_pulse; // pre-divider output
    logic [4:0] c1, c2, c3; // divider phases

    // peripheral ratio must be 2, 3 or 4 times the core ratio
    function automatic logic plc_ratio_ok(input logic [4:0] a,
                                          input logic [4:0] b);
        logic [7:0] na;
        logic [7:0] nb;
        na = {3'h0, a} + 8'h01;
        nb = {3'h0, b} + 8'h01;
        return (nb == (na << 1)) || (nb == na + (na << 1))
            || (nb == (na << 2));
    endfunction : plc_ratio_ok

    // byte-lane merge of a write into the old image
    function automatic logic [31:0] plc_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : plc_merge

    // ****************************************
    // wishbone slave
    // ****************************************
    // a write commits at the edge where ack is seen high
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // read data captured with the request, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_r <= '0;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            rd_r <= rdata;
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rdata = '0;
        case (wb_adr_i)
            PLC_A_PID: rdata = PLC_PID_VAL;
            PLC_A_CSR: begin
                rdata[PLC_CSR_EN] = loop_sel_r;
                rdata[PLC_CSR_RST] = loop_rst_r;
                rdata[PLC_CSR_LOCK] = lock_r;
                rdata[PLC_CSR_SHORT] = short_r;
            end
            PLC_A_MULT: rdata[4:0] = mult_r;
            PLC_A_DIV0: rdata = {16'h0000, den_r[0], 10'h000, d0_r};
            PLC_A_DIV1: rdata = {16'h0000, den_r[1], 10'h000, d1_r};
            PLC_A_DIV2: rdata = {16'h0000, den_r[2], 10'h000, d2_r};
            PLC_A_DIV3: rdata = {16'h0000, den_r[3], 10'h000, d3_r};
            PLC_A_STAT: begin
                rdata[PLC_STAT_BUSY] = (go_st_r != PLC_GO_IDLE);
                rdata[PLC_STAT_ERR] = go_err_r;
            end
            PLC_A_ALN: rdata[2:0] = aln_r;
            PLC_A_CLOCK_ENABLE_CONTROL: rdata[0] = clock_enable_control_r;
            PLC_A_CKST: rdata[0] = clock_enable_control_r && den_r[0];
            PLC_A_SYST: rdata[2:0] = act_en;
            default: rdata = '0; // command reads zero too
        endcase
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    // ****************************************
    // control and status
    // ****************************************
    // loop comes up disabled and held in reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_sel_r <= 1'b0;
            loop_rst_r <= 1'b1;
            clock_enable_control_r <= 1'b1;
            aln_r <= '0;
        end else if (wr) begin
            case (wb_adr_i)
                PLC_A_CSR: begin
                    if (wb_sel_i[0]) begin
                        loop_sel_r <= wb_dat_i[PLC_CSR_EN];
                        loop_rst_r <= wb_dat_i[PLC_CSR_RST];
                    end
                end
                PLC_A_ALN: if (wb_sel_i[0]) aln_r <= wb_dat_i[2:0];
                PLC_A_CLOCK_ENABLE_CONTROL: if (wb_sel_i[0]) clock_enable_control_r <= wb_dat_i[0];
                default: ;
            endcase
        end
    end

    // time the loop reset hold; an early release is flagged, the
    // flag is cleared by writing one and a new event wins the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt_r <= 4'(PLC_RST_HOLD_CYC);
            short_r <= 1'b0;
        end else begin
            if (!loop_rst_r) begin
                rst_cnt_r <= '0;
            end else if (rst_cnt_r < 4'(PLC_RST_HOLD_CYC)) begin
                rst_cnt_r <= rst_cnt_r + 4'h1;
            end
            if (wr && wb_adr_i == PLC_A_CSR && wb_sel_i[0]
                && loop_rst_r && !wb_dat_i[PLC_CSR_RST]
                && rst_cnt_r < 4'(PLC_RST_HOLD_CYC - 1)) begin
                short_r <= 1'b1;
            end else if (wr && wb_adr_i == PLC_A_CSR && wb_sel_i[0]
                         && wb_dat_i[PLC_CSR_SHORT]) begin
                short_r <= 1'b0;
            end
        end
    end

    // lock wait restarts on reset, multiplier or pre-divider writes
    always_ff @(posedge clk_i) begin
        if (rst_i || loop_rst_r
            || (wr && (wb_adr_i == PLC_A_MULT
                       || wb_adr_i == PLC_A_DIV0))) begin
            lock_cnt_r <= '0;
            lock_r <= 1'b0;
        end else if (lock_cnt_r != 16'(LOCK_CYC)) begin
            lock_cnt_r <= lock_cnt_r + 16'h0001;
            lock_r <= (lock_cnt_r == 16'(LOCK_CYC - 1));
        end
    end

    // ****************************************
    // multiplier and divider registers
    // ****************************************
    // out-of-range multiplier writes are dropped
    assign mult_wr = plc_merge({27'h0, mult_r}, wb_dat_i, wb_sel_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mult_r <= PLC_MULT_RST;
        end else if (wr && wb_adr_i == PLC_A_MULT
                     && mult_wr[4:0] >= PLC_MULT_MIN
                     && mult_wr[4:0] <= PLC_MULT_MAX) begin
            mult_r <= mult_wr[4:0];
        end
    end

    // written ratios only; post-dividers wait for go
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d0_r <= PLC_D0_RST;
            d1_r <= PLC_D1_RST;
            d2_r <= PLC_D2_RST;
            d3_r <= PLC_D3_RST;
            den_r <= 4'hF;
        end else if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                PLC_A_DIV0: d0_r <= wb_dat_i[4:0];
                PLC_A_DIV1: d1_r <= wb_dat_i[4:0];
                PLC_A_DIV2: d2_r <= wb_dat_i[4:0];
                PLC_A_DIV3: d3_r <= wb_dat_i[4:0];
                default: ;
            endcase
        end
        if (!rst_i && wr && wb_sel_i[1]) begin
            case (wb_adr_i)
                PLC_A_DIV0: den_r[0] <= wb_dat_i[PLC_DIV_EN];
                PLC_A_DIV1: den_r[1] <= wb_dat_i[PLC_DIV_EN];
                PLC_A_DIV2: den_r[2] <= wb_dat_i[PLC_DIV_EN];
                PLC_A_DIV3: den_r[3] <= wb_dat_i[PLC_DIV_EN];
                default: ;
            endcase
        end
    end

    // ****************************************
    // go sequencer
    // ****************************************
    assign go_ok = plc_ratio_ok(d1_r, d2_r);
    assign act_ok = plc_ratio_ok(act_d1, act_d2);

    // go written: apply next cycle; a second go while busy is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_st_r <= PLC_GO_IDLE;
            go_err_r <= 1'b0;
            restart_r <= 1'b0;
        end else begin
            restart_r <= 1'b0;
            unique case (go_st_r)
                PLC_GO_IDLE: begin
                    if (wr && wb_adr_i == PLC_A_CMD && wb_sel_i[0]
                        && wb_dat_i[PLC_CMD_GO]) begin
                        go_st_r <= PLC_GO_APPLY;
                    end
                end
                PLC_GO_APPLY: begin
                    go_st_r <= PLC_GO_IDLE;
                    go_err_r <= !go_ok;
                    restart_r <= go_ok;
                end
            endcase
        end
    end

    // applied ratios change only at a legal go
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_d1 <= PLC_D1_RST;
            act_d2 <= PLC_D2_RST;
            act_d3 <= PLC_D3_RST;
            act_en <= 3'h7;
        end else if (go_st_r == PLC_GO_APPLY && go_ok) begin
            act_d1 <= d1_r;
            act_d2 <= d2_r;
            act_d3 <= d3_r;
            act_en <= den_r[3:1];
        end
    end

    // ****************************************
    // reference and clock sources
    // ****************************************
    // both sources are ored, the unused one must sit low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ref_lvl_r <= 1'b0;
        end else begin
            osc_s1 <= oscillator_input_i;
            osc_s2 <= osc_s1;
            ext_s1 <= external_clock_input_i;
            ext_s2 <= ext_s1;
            ref_lvl_r <= osc_s2 || ext_s2;
        end
    end

    assign ref_tick = (osc_s2 || ext_s2) && !ref_lvl_r;
    // clk_i stands in for the loop output; bypass uses the reference
    assign loop_run = loop_sel_r && !loop_rst_r;
    assign sys_tick = loop_run ? 1'b1 : ref_tick;
    assign loop_select_enable_o = loop_sel_r;

    // ****************************************
    // dividers
    // ****************************************
    // pre-divider on the reference, free running
    plc_div u_pre (.clk_i(clk_i), .rst_i(rst_i), .tick_i(ref_tick),
        .restart_i(1'b0), .run_i(den_r[0]), .ratio_i(d0_r),
        .pulse_o(aux_pulse), .cnt_o());
    // only aligned dividers restart, so unaligned ones keep phase
    plc_div u_core (.clk_i(clk_i), .rst_i(rst_i), .tick_i(sys_tick),
        .restart_i(restart_r && aln_r[0]), .run_i(act_en[0]),
        .ratio_i(act_d1), .pulse_o(core_clk_en_o), .cnt_o(c1));
    plc_div u_per (.clk_i(clk_i), .rst_i(rst_i), .tick_i(sys_tick),
        .restart_i(restart_r && aln_r[1]), .run_i(act_en[1]),
        .ratio_i(act_d2), .pulse_o(periph_clk_en_o), .cnt_o(c2));
    plc_div u_mem (.clk_i(clk_i), .rst_i(rst_i), .tick_i(sys_tick),
        .restart_i(restart_r && aln_r[2]), .run_i(act_en[2]),
        .ratio_i(act_d3), .pulse_o(mem_clk_en_o), .cnt_o(c3));

    assign ref_clk_en_o = aux_pulse && clock_enable_control_r;

    // ****************************************
    // checks
    // ****************************************
    chk_reset_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !loop_select_enable_o && loop_rst_r)
        else $error("loop not disabled after reset");

    chk_ref_source: assert property (@(posedge clk_i) disable iff (rst_i)
        ref_clk_en_o |-> $past(ref_tick))
        else $error("reference pulse without reference edge");

    chk_bypass_src: assert property (@(posedge clk_i) disable iff (rst_i)
        core_clk_en_o && !$past(loop_run) |-> $past(ref_tick))
        else $error("bypass core clock not from reference");

    chk_aligned_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        restart_r && aln_r == 3'h7 |=> c1 == 5'h00 && c2 == 5'h00
            && c3 == 5'h00 && !core_clk_en_o)
        else $error("aligned dividers not restarted together");

    chk_mult_range: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(mult_r) |-> mult_r >= PLC_MULT_MIN
            && mult_r <= PLC_MULT_MAX)
        else $error("multiplier outside allowed range");

    chk_core_default: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> act_d1 == PLC_D1_RST && d1_r == 5'h00)
        else $error("core divider default wrong");

    chk_periph_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) || restart_r |-> act_ok && act_d2 != act_d1)
        else $error("peripheral ratio not 2, 3 or 4 of core");

    chk_mem_default: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> act_d3 == PLC_D3_RST && d3_r == 5'h02)
        else $error("memory divider default wrong");

    chk_go_apply: assert property (@(posedge clk_i) disable iff (rst_i)
        go_st_r == PLC_GO_APPLY && go_ok |=> restart_r
            && act_d1 == $past(d1_r) && act_d3 == $past(d3_r))
        else $error("go did not apply pending ratios");

    chk_hold_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        go_st_r == PLC_GO_IDLE |=> $stable(act_d1) && $stable(act_d2)
            && $stable(act_d3))
        else $error("ratio changed without go");

endmodule : plc_ctrl

// *** plc_src_model.sv ***
// plc_src_model: reference source, crystal oscillator or clock pin
module plc_src_model #(
    parameter int HALF_NS = 200 // half period of the reference
) (
    input wire logic osc_run_i, // crystal running
    input wire logic ext_run_i, // clock pin driven
    output logic osc_o, // oscillator_input
    output logic ext_o // external_clock_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // sources
    // ****************************************
    // an idle source sits at ground, as an unused input is tied off
    initial begin
        osc_o = 1'b0;
        ext_o = 1'b0;
        forever begin
            #HALF_NS;
            osc_o = osc_run_i ? ~osc_o : 1'b0;
            ext_o = ext_run_i ? ~ext_o : 1'b0;
        end
    end
endmodule : plc_src_model

// *** tb.sv ***
// tb: register-level bench of the pll clock controller
module tb
    import plc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 20; // shortened lock wait
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = '0;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic osc_run = 1'b0, ext_run = 1'b0, osc, ext;
    logic core_en, per_en, mem_en, ref_en, sel_o;
    int mismatches = 0;
    int n_compared = 0;
    int cnt[4];
    // multiplier writes, and what must read back
    logic [31:0] mw[4] = '{32'h0000_0019, 32'h0000_0002,
                           32'h0000_0003, 32'h0000_0018};
    logic [31:0] me[4] = '{32'h0000_000C, 32'h0000_000C,
                           32'h0000_0003, 32'h0000_0018};
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    plc_ctrl #(.LOCK_CYC(LOCK)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .oscillator_input_i(osc), .external_clock_input_i(ext),
        .core_clk_en_o(core_en), .periph_clk_en_o(per_en),
        .mem_clk_en_o(mem_en), .ref_clk_en_o(ref_en),
        .loop_select_enable_o(sel_o));
    plc_src_model i_src (.osc_run_i(osc_run), .ext_run_i(ext_run),
        .osc_o(osc), .ext_o(ext));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // one classic cycle; held until ack is sampled, then one idle cycle
    task automatic bus(input logic we, input logic [31:0] a,
                       input logic [31:0] d);
        int i;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) begin
            mismatches++;
            finish_test();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    // pulses of core, peripheral, memory and reference over n cycles
    task automatic count(input int n);
        cnt = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge clk_i);
            cnt[0] += int'(core_en === 1'b1);
            cnt[1] += int'(per_en === 1'b1);
            cnt[2] += int'(mem_en === 1'b1);
            cnt[3] += int'(ref_en === 1'b1);
        end
    endtask : count
    task automatic exp3(input int a, input int b, input int c);
        count(60);
        chk(cnt[0], a);
        chk(cnt[1], b);
        chk(cnt[2], c);
    endtask : exp3
    // write the peripheral ratio, go, then a margin past the apply
    task automatic go(input logic [31:0] d2);
        wr(PLC_A_DIV2, d2);
        wr(PLC_A_CMD, 32'h0000_0001);
        repeat (4) @(posedge clk_i);
    endtask : go
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(sel_o, 1'b0);
        rdc(PLC_A_PID, PLC_PID_VAL);
        rdc(PLC_A_CSR, 32'h0000_0008);
        rdc(PLC_A_MULT, 32'h0000_000C);
        rdc(PLC_A_DIV1, 32'h0000_8000);
        rdc(PLC_A_DIV2, 32'h0000_8001);
        rdc(PLC_A_DIV3, 32'h0000_8002);
        rdc(PLC_A_SYST, 32'h0000_0007);
        rdc(PLC_A_CKST, 32'h0000_0001);
        rdc(32'h4100_0200, 32'h0000_0000);
        foreach (mw[k]) begin
            wr(PLC_A_MULT, mw[k]);
            rdc(PLC_A_MULT, me[k]);
        end
        $display("reset and multiplier test done");
        // bypass: pulses follow whichever reference runs
        osc_run <= 1'b1;
        count(20);
        count(200);
        chk(32'(cnt[3] inside {[19:21]}), 1);
        chk(32'(cnt[0] inside {[19:21]}), 1);
        osc_run <= 1'b0;
        ext_run <= 1'b1;
        count(20);
        count(200);
        chk(32'(cnt[3] inside {[19:21]}), 1);
        ext_run <= 1'b0;
        count(20);
        count(40);
        chk(cnt[3], 0);
        $display("reference test done");
        // configure, release the loop reset, lock wait, select the loop
        wr(PLC_A_ALN, 32'h0000_0007);
        rdc(PLC_A_ALN, 32'h0000_0007);
        wr(PLC_A_DIV0, 32'h0000_8000);
        wr(PLC_A_MULT, 32'h0000_0018);
        wr(PLC_A_CSR, 32'h0000_0000);
        rdc(PLC_A_CSR, 32'h0000_0000);
        // a release after 3 cycles of reset is flagged, write one clears
        wr(PLC_A_CSR, 32'h0000_0008);
        wr(PLC_A_CSR, 32'h0000_0000);
        rdc(PLC_A_CSR, 32'h0000_0080);
        wr(PLC_A_CSR, 32'h0000_0080);
        rdc(PLC_A_CSR, 32'h0000_0000);
        repeat (LOCK + 2) @(posedge clk_i);
        rdc(PLC_A_CSR, 32'h0000_0040);
        wr(PLC_A_CSR, 32'h0000_0001);
        chk(sel_o, 1'b1);
        exp3(60, 30, 20);
        wr(PLC_A_DIV1, 32'h0000_8001);
        wr(PLC_A_DIV2, 32'h0000_8003);
        exp3(60, 30, 20);
        go(32'h0000_8003);
        exp3(30, 15, 20);
        go(32'h0000_8004);
        rdc(PLC_A_STAT, 32'h0000_0002);
        exp3(30, 15, 20);
        go(32'h0000_8005);
        exp3(30, 10, 20);
        $display("divider test done");
        finish_test();
    end
endmodule : tb
